// [hw/reset_cause_map.vh]
// Bit layout, reset values and codes of the reset cause and status register.
// Assumes a single 32-bit register word reached through the core and host ports.
`ifndef RESET_CAUSE_MAP_VH
`define RESET_CAUSE_MAP_VH

// ==========================================================
// Register width
`define REG_WIDTH            32

// ==========================================================
// Field positions
`define BIT_DEV_RESET_SEEN   0
`define BIT_PCI_RESET_SEEN   1
`define BIT_WARM_RESET_SEEN  2
`define BIT_IRQ_REQUEST      3
`define BIT_IRQ_REARM        4
`define BIT_CFG_LOAD_DONE    5
`define BIT_CFG_CHECKSUM_ERR 6

// ==========================================================
// Reset values
`define RST_DEV_RESET_SEEN   1'b1
`define RST_PCI_RESET_SEEN   1'b0
`define RST_WARM_RESET_SEEN  1'b0
`define RST_CFG_LOAD_DONE    1'b0
`define RST_CFG_CHECKSUM_ERR 1'b0
`define RST_IRQ_LINE         1'b0
`define RST_IRQ_ARMED        1'b1
`define RST_WORD             32'h0000_0000

// ==========================================================
// Power state codes that allow a warm reset
`define PM_STATE_D2          2'h2
`define PM_STATE_D3          2'h3

`endif

// [hw/sync2_level.v]
// Two flip-flop synchroniser for one level signal.
// Assumes the input is asynchronous to ref_clk_i; reset loads a constant idle value.
`timescale 1ns/1ps

module sync2_level #(
    parameter RESET_VALUE = 1'b1
) (
    // Clock and reset
    input  wire ref_clk_i,
    input  wire rst_i,
    // Level in and out
    input  wire async_i,
    output wire sync_o
);

    // ==========================================================
    // Synchroniser stages
    reg meta_reg;
    reg sync_reg;

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            meta_reg <= RESET_VALUE;
            sync_reg <= RESET_VALUE;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule

// [hw/pci_reset_cause_status.v]
// Reset cause and status register with host interrupt request and re-arm control.
// Assumes the core and host ports run on ref_clk_i, the PCI reset pin is asynchronous,
// and the loader, warm reset and mask inputs come from logic on ref_clk_i.
//
// Function
// RULE1 - Reading clears the three reset indicator bits
// RULE2 - Bits 31 to 7 read zero, ignore writes
// RULE3 - Bit 6 flags configuration checksum failure, read-only
// RULE4 - Checksum error cleared by PCI reset only
// RULE5 - Bit 5 flags configuration load done, read-only
// RULE6 - Writing 1 to bit 4 deasserts, re-arms interrupt
// RULE7 - No new host interrupt until re-arm write
// RULE8 - Writing 1 to bit 3 raises interrupt unless masked
// RULE9 - Device or warm reset resets interrupt logic
// RULE10 - Bit 2 set by warm command or D2/D3
// RULE11 - Warm indicator holds until read or device reset
// RULE12 - Bit 1 set by PCI reset, reads 1 meanwhile
// RULE13 - PCI indicator ignores writes, cleared by read or reset
// RULE14 - Register reachable by core and by host
// RULE15 - Bit 0 shows device reset since last read
// RULE16 - Set event wins over clearing read
`timescale 1ns/1ps
`include "reset_cause_map.vh"

module pci_reset_cause_status (
    // Clock and device reset
    input  wire                    ref_clk_i,
    input  wire                    rst_i,
    // Core access port
    input  wire                    core_sel_i,
    input  wire                    core_wr_i,
    input  wire [`REG_WIDTH-1:0]   core_wdata_i,
    output wire [`REG_WIDTH-1:0]   core_rdata_o,
    output wire                    core_rvalid_o,
    output wire                    core_wack_o,
    // Host access port
    input  wire                    host_sel_i,
    input  wire                    host_wr_i,
    input  wire [`REG_WIDTH-1:0]   host_wdata_i,
    output wire [`REG_WIDTH-1:0]   host_rdata_o,
    output wire                    host_rvalid_o,
    output wire                    host_wack_o,
    // Reset and power management events
    input  wire                    pci_rst_n_i,
    input  wire                    warm_reset_command_i,
    input  wire                    pm_warm_req_i,
    input  wire [1:0]              pm_cur_state_i,
    // Configuration loader
    input  wire                    config_load_done_i,
    input  wire                    config_checksum_error_i,
    // Host interrupt
    input  wire                    host_irq_mask_i,
    output wire                    host_interrupt_line_o,
    output wire                    host_interrupt_line_oe_o
);

    // ==========================================================
    // Port count and flattened access vectors
    localparam NPORTS = 2;

    wire [NPORTS-1:0]            sel_vec;
    wire [NPORTS-1:0]            wr_vec;
    wire [NPORTS*`REG_WIDTH-1:0] wdata_vec;
    wire [NPORTS-1:0]            rd_vec;
    wire [NPORTS-1:0]            wt_vec;
    wire [NPORTS-1:0]            req_vec;
    wire [NPORTS-1:0]            rearm_vec;
    wire [NPORTS*`REG_WIDTH-1:0] rdata_vec;
    wire [NPORTS-1:0]            rvalid_vec;
    wire [NPORTS-1:0]            wack_vec;

    // Port 0 is the core, port 1 is the host
    assign sel_vec   = {host_sel_i, core_sel_i}; //RULE14
    assign wr_vec    = {host_wr_i, core_wr_i};
    assign wdata_vec = {host_wdata_i, core_wdata_i};

    // ==========================================================
    // PCI reset pin synchroniser
    wire pci_rst_n_sync;
    wire pci_rst_active;

    sync2_level #(
        .RESET_VALUE (1'b1)
    ) u_pci_rst_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .async_i   (pci_rst_n_i),
        .sync_o    (pci_rst_n_sync)
    );

    assign pci_rst_active = ~pci_rst_n_sync;

    // ==========================================================
    // State registers
    reg dev_reset_seen_reg;
    reg dev_reset_seen_next;
    reg pci_bus_reset_seen_reg;
    reg pci_bus_reset_seen_next;
    reg warm_reset_seen_reg;
    reg warm_reset_seen_next;
    reg config_load_done_reg;
    reg config_load_done_next;
    reg config_checksum_error_reg;
    reg config_checksum_error_next;
    reg irq_line_reg;
    reg irq_line_next;
    reg irq_armed_reg;
    reg irq_armed_next;
    reg [`REG_WIDTH-1:0] status_word;

    // ==========================================================
    // Per-port decode and read return
    genvar g;
    generate
        for (g = 0; g < NPORTS; g = g + 1) begin : port_g
            reg [`REG_WIDTH-1:0] rdata_reg;
            reg                  rvalid_reg;
            reg                  wack_reg;

            assign rd_vec[g]    = sel_vec[g] & ~wr_vec[g];
            assign wt_vec[g]    = sel_vec[g] & wr_vec[g];
            assign req_vec[g]   = wt_vec[g] & wdata_vec[g*`REG_WIDTH + `BIT_IRQ_REQUEST]; //RULE8
            assign rearm_vec[g] = wt_vec[g] & wdata_vec[g*`REG_WIDTH + `BIT_IRQ_REARM]; //RULE6

            always @(posedge ref_clk_i) begin
                if (rst_i) begin
                    rdata_reg  <= `RST_WORD;
                    rvalid_reg <= 1'b0;
                    wack_reg   <= 1'b0;
                end else begin
                    rvalid_reg <= rd_vec[g];
                    wack_reg   <= wt_vec[g];
                    if (rd_vec[g]) begin
                        rdata_reg <= status_word; //RULE14
                    end
                end
            end

            assign rdata_vec[g*`REG_WIDTH +: `REG_WIDTH] = rdata_reg;
            assign rvalid_vec[g]                         = rvalid_reg;
            assign wack_vec[g]                           = wack_reg;
        end
    endgenerate

    assign core_rdata_o  = rdata_vec[0 +: `REG_WIDTH];
    assign host_rdata_o  = rdata_vec[`REG_WIDTH +: `REG_WIDTH];
    assign core_rvalid_o = rvalid_vec[0];
    assign host_rvalid_o = rvalid_vec[1];
    assign core_wack_o   = wack_vec[0];
    assign host_wack_o   = wack_vec[1];

    // ==========================================================
    // Combined events
    wire any_read;
    wire any_req;
    wire any_rearm;
    wire pm_warm_ok;
    wire warm_event;

    assign any_read   = |rd_vec; //RULE1
    assign any_req    = |req_vec;
    assign any_rearm  = |rearm_vec;
    assign pm_warm_ok = (pm_cur_state_i == `PM_STATE_D2) | (pm_cur_state_i == `PM_STATE_D3);
    assign warm_event = warm_reset_command_i | (pm_warm_req_i & pm_warm_ok); //RULE10

    // ==========================================================
    // Read value
    always @* begin
        status_word                        = `RST_WORD; //RULE2
        status_word[`BIT_DEV_RESET_SEEN]   = dev_reset_seen_reg;
        status_word[`BIT_PCI_RESET_SEEN]   = pci_bus_reset_seen_reg | pci_rst_active; //RULE12
        status_word[`BIT_WARM_RESET_SEEN]  = warm_reset_seen_reg;
        status_word[`BIT_CFG_LOAD_DONE]    = config_load_done_reg;
        status_word[`BIT_CFG_CHECKSUM_ERR] = config_checksum_error_reg;
    end

    // ==========================================================
    // Reset indicator next values
    always @* begin
        dev_reset_seen_next = dev_reset_seen_reg;
        if (any_read) begin
            dev_reset_seen_next = 1'b0; //RULE15
        end
    end

    always @* begin
        pci_bus_reset_seen_next = pci_bus_reset_seen_reg;
        if (pci_rst_active) begin
            pci_bus_reset_seen_next = 1'b1; //RULE16
        end else if (any_read) begin
            pci_bus_reset_seen_next = 1'b0; //RULE13
        end
    end

    always @* begin
        warm_reset_seen_next = warm_reset_seen_reg; //RULE11
        if (warm_event) begin
            warm_reset_seen_next = 1'b1; //RULE16
        end else if (any_read) begin
            warm_reset_seen_next = 1'b0; //RULE11
        end
    end

    // ==========================================================
    // Configuration flags next values
    always @* begin
        config_load_done_next = config_load_done_reg;
        if (config_load_done_i) begin
            config_load_done_next = 1'b1; //RULE5
        end
    end

    always @* begin
        config_checksum_error_next = config_checksum_error_reg;
        if (pci_rst_active) begin
            config_checksum_error_next = `RST_CFG_CHECKSUM_ERR; //RULE4
        end else if (config_checksum_error_i) begin
            config_checksum_error_next = 1'b1; //RULE3
        end
    end

    // ==========================================================
    // Host interrupt control next values
    always @* begin
        irq_line_next  = irq_line_reg;
        irq_armed_next = irq_armed_reg;
        if (any_rearm) begin
            irq_line_next  = 1'b0; //RULE6
            irq_armed_next = 1'b1; //RULE6
        end else if (any_req && !host_irq_mask_i && irq_armed_reg) begin
            irq_line_next  = 1'b1; //RULE8
            irq_armed_next = 1'b0; //RULE7
        end
    end

    // ==========================================================
    // Device reset seen flag
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            dev_reset_seen_reg <= `RST_DEV_RESET_SEEN; //RULE15
        end else begin
            dev_reset_seen_reg <= dev_reset_seen_next;
        end
    end

    // ==========================================================
    // PCI reset seen flag
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            pci_bus_reset_seen_reg <= `RST_PCI_RESET_SEEN; //RULE13
        end else begin
            pci_bus_reset_seen_reg <= pci_bus_reset_seen_next;
        end
    end

    // ==========================================================
    // Warm reset seen flag
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            warm_reset_seen_reg <= `RST_WARM_RESET_SEEN; //RULE11
        end else begin
            warm_reset_seen_reg <= warm_reset_seen_next;
        end
    end

    // ==========================================================
    // Configuration load done flag
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            config_load_done_reg <= `RST_CFG_LOAD_DONE; //RULE5
        end else begin
            config_load_done_reg <= config_load_done_next;
        end
    end

    // Checksum error survives device reset
    always @(posedge ref_clk_i) begin
        config_checksum_error_reg <= config_checksum_error_next; //RULE4
    end

    // Interrupt line on device or warm reset
    always @(posedge ref_clk_i) begin
        if (rst_i || warm_event) begin
            irq_line_reg <= `RST_IRQ_LINE; //RULE9
        end else begin
            irq_line_reg <= irq_line_next;
        end
    end

    // Interrupt arm state on device or warm reset
    always @(posedge ref_clk_i) begin
        if (rst_i || warm_event) begin
            irq_armed_reg <= `RST_IRQ_ARMED; //RULE9
        end else begin
            irq_armed_reg <= irq_armed_next;
        end
    end

    // ==========================================================
    // Open-drain host interrupt pin, pulled low while asserted
    assign host_interrupt_line_o    = 1'b0;
    assign host_interrupt_line_oe_o = irq_line_reg;

endmodule

// [test/rcs_props.sv]
// Checker for the reset cause and status register block.
// Assumes ports named as on the design top; attached by bind below.
`timescale 1ns/1ps
module rcs_props (
    input wire logic        ref_clk_i, rst_i, core_sel_i, core_wr_i, host_sel_i, host_wr_i,
    input wire logic        core_rvalid_o, host_wack_o, pci_rst_n_i, warm_reset_command_i,
    input wire logic        pm_warm_req_i, config_load_done_i, config_checksum_error_i,
    input wire logic        host_irq_mask_i, host_interrupt_line_oe_o,
    input wire logic [1:0]  pm_cur_state_i,
    input wire logic [31:0] core_wdata_i, core_rdata_o, host_wdata_i, host_rdata_o
);
    // ====
    // Helpers
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    wire rd_c  = core_sel_i && !core_wr_i;
    wire rd_h  = host_sel_i && !host_wr_i;
    wire rearm = (core_sel_i && core_wr_i && core_wdata_i[4]) || (host_sel_i && host_wr_i && host_wdata_i[4]);
    wire raise = (core_sel_i && core_wr_i && core_wdata_i[3]) || (host_sel_i && host_wr_i && host_wdata_i[3]);
    wire warm  = warm_reset_command_i || (pm_warm_req_i && pm_cur_state_i[1]);
    sequence s_two_reads;
        rd_c ##1 rd_c;
    endsequence
    sequence s_pci_held;
        (!pci_rst_n_i && !config_checksum_error_i)[*5];
    endsequence
    // ====
    // Properties
    AST_RESERVED: assert property (core_rvalid_o |-> core_rdata_o[31:7] == 25'h0 && core_rdata_o[4:3] == 2'h0)
        else $error("reserved or write-only bits read nonzero");
    AST_CLEAR: assert property (s_two_reads |=> core_rdata_o[0] == 1'b0)
        else $error("device reset bit not cleared by read");
    AST_PCI: assert property (s_pci_held ##0 rd_c |=> core_rdata_o[1] && !core_rdata_o[6])
        else $error("pci reset bit or checksum bit wrong during pci reset");
    AST_DONE: assert property (config_load_done_i ##[1:4] rd_c |=> core_rdata_o[5])
        else $error("load done bit not set");
    AST_WARM_KEEP: assert property (warm_reset_command_i && rd_h ##1 !(rd_c || rd_h) ##1 rd_h |=> host_rdata_o[2])
        else $error("warm event lost against clearing read");
    AST_RISE: assert property ($rose(host_interrupt_line_oe_o) |-> $past(raise && !host_irq_mask_i))
        else $error("interrupt raised without unmasked request");
    AST_REARM: assert property (rearm |=> !host_interrupt_line_oe_o)
        else $error("re-arm write left interrupt asserted");
    AST_WARM_DROP: assert property (warm |=> !host_interrupt_line_oe_o)
        else $error("warm event left interrupt asserted");
    AST_HOLD: assert property (host_interrupt_line_oe_o && !rearm && !warm |=> host_interrupt_line_oe_o)
        else $error("interrupt dropped without re-arm");
    AST_CORE_RVALID: assert property (rd_c |=> core_rvalid_o)
        else $error("core read not answered");
    AST_HOST_WACK: assert property (host_sel_i && host_wr_i |=> host_wack_o)
        else $error("host write not acknowledged");
endmodule
bind pci_reset_cause_status rcs_props rcs_props_i (.*);

// [test/host_pin_model.sv]
// Host side of the open-drain interrupt pin, with pull-up and edge count.
// Assumes oe high means the pin is pulled low.
`timescale 1ns/1ps
module host_pin_model (
    input  wire logic ref_clk_i,
    input  wire logic line_i,
    input  wire logic oe_i,
    output wire logic line_n_o,
    output int        irq_count
);
    logic prev = 1'b1;
    assign line_n_o = oe_i ? line_i : 1'b1;
    initial irq_count = 0;
    always @(posedge ref_clk_i) begin
        if (prev && !line_n_o)
            irq_count <= irq_count + 1;
        prev <= line_n_o;
    end
endmodule

// [test/pci_reset_cause_status_tb.sv]
// Self-checking bench for the reset cause and status register.
// Assumes the design and host pin model compile before it.
`timescale 1ns/1ps
module pci_reset_cause_status_tb;
    logic ref_clk_i = 0, rst_i = 1, pci_n = 0, wcmd = 0, pmreq = 0, done = 0, cerr = 0, mask = 0, wr = 0;
    logic [1:0]  pms = 0, sel = 0;
    logic [31:0] wd = 0;
    wire  [31:0] crd, hrd;
    wire         crv, hrv, cwa, hwa, line, oe, line_n;
    int          errors = 0, cmp_count = 0, irqs, m_dev, m_pci, m_warm, m_done, m_err, m_live, m_arm, m_line;
    pci_reset_cause_status pci_reset_cause_status_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .core_sel_i(sel[0]), .core_wr_i(wr), .core_wdata_i(wd), .core_rdata_o(crd), .core_rvalid_o(crv),
        .core_wack_o(cwa), .host_sel_i(sel[1]), .host_wr_i(wr), .host_wdata_i(wd), .host_rdata_o(hrd),
        .host_rvalid_o(hrv), .host_wack_o(hwa), .pci_rst_n_i(pci_n), .warm_reset_command_i(wcmd),
        .pm_warm_req_i(pmreq), .pm_cur_state_i(pms), .config_load_done_i(done),
        .config_checksum_error_i(cerr), .host_irq_mask_i(mask), .host_interrupt_line_o(line),
        .host_interrupt_line_oe_o(oe));
    host_pin_model host_pin_model_i (.ref_clk_i(ref_clk_i), .line_i(line), .oe_i(oe), .line_n_o(line_n),
        .irq_count(irqs));
    initial forever #2.5 ref_clk_i = ~ref_clk_i;
    // ====
    // Checks and access
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic acc(input int h, input logic w, input logic [31:0] d, input logic ev);
        logic [31:0] exp;
        exp = {25'h0, m_err[0], m_done[0], 2'h0, m_warm[0], m_pci[0], m_dev[0]};
        tick(1);
        sel <= h ? 2'h2 : 2'h1;
        wr <= w;
        wd <= d;
        wcmd <= ev;
        tick(1);
        sel <= 2'h0;
        wcmd <= 1'b0;
        #1;
        if (w) begin
            chk_bit(h ? hwa : cwa, 1'b1);
            if (d[4]) begin
                m_arm = 1;
                m_line = 0;
            end else if (d[3] && !mask && m_arm) begin
                m_line = 1;
                m_arm = 0;
            end
        end else begin
            chk_bit(h ? hrv : crv, 1'b1);
            chk_word(h ? hrd : crd, exp);
            m_dev = 0;
            m_warm = ev;
            m_pci = m_live;
        end
        if (ev) m_line = 0;
        if (ev) m_arm = 1;
        chk_bit(oe, m_line[0]);
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        complete_run;
    end
    // ====
    // Sequence
    initial begin
        void'($urandom(39));
        m_dev = 1; m_pci = 0; m_warm = 0; m_done = 0; m_err = 0; m_live = 0; m_arm = 1; m_line = 0;
        tick(20);
        rst_i <= 0;
        tick(3);
        pci_n <= 1;
        tick(4);
        m_pci = 1;
        acc(0, 0, 0, 0);
        acc(1, 0, 0, 0);
        acc(0, 1, $urandom & 32'hffff_ffe7, 0);
        acc(1, 1, $urandom & 32'hffff_ffe7, 0);
        acc(0, 0, 0, 0);
        tick(1);
        done <= 1;
        cerr <= 1;
        tick(1);
        done <= 0;
        cerr <= 0;
        m_done = 1;
        m_err = 1;
        acc(1, 0, 0, 0);
        for (int s = 0; s < 4; s++) begin
            tick(1);
            pms <= s[1:0];
            pmreq <= 1;
            tick(1);
            pmreq <= 0;
            m_warm = (s >= 2);
            acc(0, 0, 0, 0);
        end
        acc(1, 0, 0, 1);
        acc(1, 0, 0, 0);
        $display("status tests done");
        tick(1);
        mask <= 1;
        acc(0, 1, 32'h8, 0);
        tick(1);
        mask <= 0;
        acc(1, 1, 32'h8, 0);
        acc(0, 1, 32'h8, 0);
        acc(0, 1, 32'h18, 0);
        acc(0, 1, 32'h8, 0);
        acc(0, 0, 0, 1);
        chk_word(irqs, 32'h2);
        $display("interrupt tests done");
        tick(1);
        pci_n <= 0;
        tick(5);
        m_live = 1; m_pci = 1; m_err = 0;
        acc(0, 0, 0, 0);
        acc(1, 0, 0, 0);
        tick(1);
        pci_n <= 1;
        tick(4);
        m_live = 0;
        acc(0, 0, 0, 0);
        acc(0, 0, 0, 0);
        tick(1);
        cerr <= 1;
        tick(1);
        cerr <= 0;
        m_err = 1;
        acc(0, 1, 32'h8, 0);
        tick(1);
        rst_i <= 1;
        tick(20);
        rst_i <= 0;
        m_dev = 1; m_done = 0; m_warm = 0; m_pci = 0; m_arm = 1; m_line = 0;
        tick(1);
        sel <= 2'h1;
        wr <= 1'b0;
        tick(1);
        #1;
        chk_word(crd, {25'h0, m_err[0], 6'h01});
        @(posedge ref_clk_i);
        sel <= 2'h0;
        #1;
        chk_word(crd, {25'h0, m_err[0], 6'h00});
        m_dev = 0;
        acc(1, 0, 0, 0);
        $display("reset tests done");
        complete_run;
    end
endmodule
